// ==== hw/bo_seq_regs.svh ====
`ifndef BO_SEQ_REGS_SVH
`define BO_SEQ_REGS_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
// ctrl fields
`define CTRL_PWR_OK_BIT 0
`define CTRL_SUPPLY_START_BIT 1
`define CTRL_RESET 8'h00
`define IRQ_MASK_RESET 4'h0
// irq status bits
`define IRQ_FAULT_SET 0
`define IRQ_FAULT_CLR 1
`define IRQ_OC 2
`define IRQ_OP 3
// timing
`define CLK_HZ 100000000
`define BLANK_MS 50
`define WINDOW_MS 50
`define BLANK_MIN_MS 25
`define LINE_THRESH_MV 1000
`define CLAMP_MV 980
`define SINK_UA 7
`define OC_THRESH_UA 200
`define OP_THRESH_UVA 275
`endif

// ==== hw/bo_seq_pkg.sv ====
package bo_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BLANK = 2'b01,
        ST_WINDOW = 2'b10,
        ST_FAULT = 2'b11
    } seq_state_e;
    typedef struct packed {
        logic undervoltage;
        logic overcurrent;
        logic overpower;
    } cmp_s;
    typedef struct packed {
        logic driver_en;
        logic ctrl_ground;
        logic hold_clamp;
        logic hysteresis_sink;
        logic sense_pulldown;
    } analog_ctl_s;
endpackage

// ==== hw/sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 3
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    // meta feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== hw/line_brownout_fault_sequencer.sv ====
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bo_seq_regs.svh"
// Notes on behaviour
// - comparator high when line below threshold
// - on undervoltage connect clamp, start blanking
// - faults ignored while blanking runs
// - blanking never shorter than minimum
// - blanking end opens confirmation window
// - undervoltage in window raises fault flag
// - quiet window leaves fault flag low
// - fault disables driver, grounds control node
// - fault removes clamp, enables hysteresis sink once started
// - not ready holds sense low, fault high
// - ready releases pulldown, turns sink off unless in fault
// - sink on when off, except before start
// - overcurrent forces drive low
// - overcurrent recovery automatic, no latch
// - overpower turns driver off
// - overpower release automatic
module line_brownout_fault_sequencer #(
    parameter int BLANK_CYC = (`BLANK_MS * (`CLK_HZ / 1000)),
    parameter int WINDOW_CYC = (`WINDOW_MS * (`CLK_HZ / 1000))
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic undervoltage_compare_i,
    input wire logic overcurrent_i,
    input wire logic overpower_i,
    input wire logic pwm_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic line_fault_flag_o,
    output logic gate_drive_o,
    output logic ctrl_ground_o,
    output logic hold_clamp_o,
    output logic hysteresis_sink_o,
    output logic sense_pulldown_o,
    output logic irq_o
);
    localparam int CNT_W = 32;

    bo_seq_pkg::cmp_s cmp_raw;
    bo_seq_pkg::cmp_s cmp;
    bo_seq_pkg::seq_state_e state;
    bo_seq_pkg::seq_state_e next_state;
    bo_seq_pkg::analog_ctl_s actl;

    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] next_timer;
    logic blank_done;
    logic window_done;

    logic [7:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] irq_evt;

    logic ready;
    logic started;
    logic fault_q;
    logic fault_rise;
    logic fault_fall;
    logic oc_q;
    logic op_q;
    logic oc_cut;
    logic op_cut;

    logic req;
    logic wr;
    logic next_ack;
    logic [31:0] next_rdata;

    assign cmp_raw = '{undervoltage: undervoltage_compare_i, overcurrent: overcurrent_i, overpower: overpower_i};

    // comparators arrive asynchronously from the analog side
    sync2 #(.W(3)) sync2_i (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .d_i(cmp_raw),
        .q_o(cmp)
    );

    // software reports supply, on/off, bulk and thermal health
    assign ready = ctrl[`CTRL_PWR_OK_BIT];

    // started latches once the supply first reaches its start level
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            started <= 1'b0;
        end else if (ctrl[`CTRL_SUPPLY_START_BIT]) begin
            started <= 1'b1;
        end
    end

    // terminal counts; the nominal count costs flops but keeps the minimum blanking guaranteed
    assign blank_done = (timer == CNT_W'(BLANK_CYC - 1));
    assign window_done = (timer == CNT_W'(WINDOW_CYC - 1));

    // comparator high means line below threshold
    always_comb begin
        next_state = state;
        unique case (state)
            bo_seq_pkg::ST_FAULT: begin
                if (!cmp.undervoltage) begin
                    next_state = bo_seq_pkg::ST_IDLE;
                end
            end
            bo_seq_pkg::ST_IDLE: begin
                if (cmp.undervoltage) begin
                    next_state = bo_seq_pkg::ST_BLANK;
                end
            end
            bo_seq_pkg::ST_BLANK: begin
                // the comparator is ignored here; full count also covers the minimum
                if (blank_done) begin
                    next_state = bo_seq_pkg::ST_WINDOW;
                end
            end
            bo_seq_pkg::ST_WINDOW: begin
                if (cmp.undervoltage) begin
                    next_state = bo_seq_pkg::ST_FAULT;
                end else if (window_done) begin
                    next_state = bo_seq_pkg::ST_IDLE;
                end
            end
        endcase
        // not ready forces the fault state, so start-up always begins with the flag high
        if (!ready) begin
            next_state = bo_seq_pkg::ST_FAULT;
        end
    end

    always_comb begin
        next_timer = '0;
        // a state change restarts the count, so every sequence starts from zero
        if (ready && (next_state == state)) begin
            if ((state == bo_seq_pkg::ST_BLANK) || (state == bo_seq_pkg::ST_WINDOW)) begin
                next_timer = timer + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= bo_seq_pkg::ST_FAULT;
        end else begin
            state <= next_state;
        end
    end

    // the count only runs in blank and window states
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    assign fault_q = (state == bo_seq_pkg::ST_FAULT);
    // edges of the fault state, seen one cycle before the flag pin moves
    assign fault_rise = fault_q && !line_fault_flag_o;
    assign fault_fall = !fault_q && line_fault_flag_o;

    // over-current and over-power gate each cycle; nothing is latched, so recovery is immediate
    assign oc_cut = cmp.overcurrent;
    assign op_cut = cmp.overpower;

    // pulldown waits for the fault state so the flag never lags it
    always_comb begin
        actl.driver_en = !fault_q && !oc_cut && !op_cut;
        actl.ctrl_ground = fault_q;
        actl.hold_clamp = (state == bo_seq_pkg::ST_BLANK) || (state == bo_seq_pkg::ST_WINDOW);
        actl.sense_pulldown = !ready && fault_q;
        actl.hysteresis_sink = started && (fault_q || !ready);
    end

    // outputs registered to keep the analog switches glitch free
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_fault_flag_o <= 1'b1;
        end else begin
            line_fault_flag_o <= fault_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gate_drive_o <= 1'b0;
        end else begin
            gate_drive_o <= pwm_i && actl.driver_en;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_ground_o <= 1'b1;
        end else begin
            ctrl_ground_o <= actl.ctrl_ground;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_clamp_o <= 1'b0;
        end else begin
            hold_clamp_o <= actl.hold_clamp;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hysteresis_sink_o <= 1'b0;
        end else begin
            hysteresis_sink_o <= actl.hysteresis_sink;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sense_pulldown_o <= 1'b1;
        end else begin
            sense_pulldown_o <= actl.sense_pulldown;
        end
    end

    // event edges for the interrupt block
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_q <= 1'b0;
        end else begin
            oc_q <= cmp.overcurrent;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_q <= 1'b0;
        end else begin
            op_q <= cmp.overpower;
        end
    end

    always_comb begin
        irq_evt = 4'h0;
        irq_evt[`IRQ_FAULT_SET] = fault_rise;
        irq_evt[`IRQ_FAULT_CLR] = fault_fall;
        irq_evt[`IRQ_OC] = cmp.overcurrent && !oc_q;
        irq_evt[`IRQ_OP] = cmp.overpower && !op_q;
    end

    assign req = wb_cyc_i && wb_stb_i;
    // writes land at the edge where the master sees ack, as in a classic cycle
    assign wr = req && wb_we_i && wb_ack_o && wb_sel_i[0];
    // never two acks in a row, so a held request is answered every second cycle
    assign next_ack = req && !wb_ack_o;

    // ctrl bit 0 is the overall health, bit 1 the start level
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= `CTRL_RESET;
        end else if (wr && (wb_adr_i == `REG_CTRL)) begin
            ctrl <= wb_dat_i[7:0];
        end
    end

    // mask resets closed so no interrupt fires before software is ready
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_mask <= `IRQ_MASK_RESET;
        end else if (wr && (wb_adr_i == `REG_IRQ_MASK)) begin
            irq_mask <= wb_dat_i[3:0];
        end
    end

    // a new event wins over a write-one clear in the same cycle
    for (genvar i = 0; i < 4; i++) begin : g_irq
        always_ff @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                irq_stat[i] <= 1'b0;
            end else if (irq_evt[i]) begin
                irq_stat[i] <= 1'b1;
            end else if (wr && (wb_adr_i == `REG_IRQ_STAT) && wb_dat_i[i]) begin
                irq_stat[i] <= 1'b0;
            end
        end
    end

    // level output; it stays high until software clears or masks the bit
    assign irq_o = |(irq_stat & irq_mask);

    // unmapped addresses read as zero and writes to them are dropped
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            `REG_CTRL: begin
                next_rdata = {24'h000000, ctrl};
            end
            `REG_STATUS: begin
                next_rdata = {25'h0000000, cmp.overpower, cmp.overcurrent, cmp.undervoltage, state, started, fault_q};
            end
            `REG_IRQ_STAT: begin
                next_rdata = {28'h0000000, irq_stat};
            end
            `REG_IRQ_MASK: begin
                next_rdata = {28'h0000000, irq_mask};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // one wait state: ack one cycle after the request is seen
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= next_ack;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== test/line_cmp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_cmp_model (
    input wire logic ref_clk_i,
    input wire logic uv_i,
    input wire logic oc_i,
    input wire logic op_i,
    output var bo_seq_pkg::cmp_s cmp_o = '0
);
    // levels move one edge late, so the sequencer never sees them change on its own edge
    always @(posedge ref_clk_i) begin
        cmp_o <= '{undervoltage: uv_i, overcurrent: oc_i, overpower: op_i};
    end
endmodule
`default_nettype wire

// ==== test/line_fault_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module line_fault_chk (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic overcurrent_i,
    input wire logic overpower_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic line_fault_flag_o,
    input wire logic gate_drive_o,
    input wire logic ctrl_ground_o,
    input wire logic hold_clamp_o,
    input wire logic sense_pulldown_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack; s_req |=> s_ack; endproperty
    property p_gate; gate_drive_o |-> !line_fault_flag_o; endproperty
    property p_ground; ctrl_ground_o == line_fault_flag_o; endproperty
    property p_clamp; line_fault_flag_o |-> !hold_clamp_o; endproperty
    // three cycles of pin-to-drive latency, so four samples are needed
    property p_oc; overcurrent_i [*4] |-> !gate_drive_o; endproperty
    property p_op; overpower_i [*4] |-> !gate_drive_o; endproperty
    property p_blank; $rose(hold_clamp_o) |-> !line_fault_flag_o [*8]; endproperty
    property p_pull; sense_pulldown_o |-> line_fault_flag_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single cycle pulse");
    a_gate: assert property (p_gate) else $error("driver on during fault");
    a_ground: assert property (p_ground) else $error("control node not tied to fault");
    a_clamp: assert property (p_clamp) else $error("clamp on during fault");
    a_oc: assert property (p_oc) else $error("drive not cut by overcurrent");
    a_op: assert property (p_op) else $error("drive not cut by overpower");
    a_blank: assert property (p_blank) else $error("fault inside blanking");
    a_pull: assert property (p_pull) else $error("pulldown without fault");
endmodule
`default_nettype wire

// ==== test/tb_line_brownout_fault_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_line_brownout_fault_sequencer;
    localparam int BL = 20;
    logic ref_clk_i = 0, rstn_i = 0, uv = 0, oc = 0, op = 0, pwm = 0;
    logic cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = '0;
    logic [31:0] dat = '0, q, seed = 32'h8, dat_o;
    logic ack, flt, gate, gnd, clamp, sink, pull, irq;
    bo_seq_pkg::cmp_s cmp;
    int failures = 0, checks_done = 0, n;
    always #5 ref_clk_i = ~ref_clk_i;
    line_cmp_model line_cmp_model_i (.ref_clk_i(ref_clk_i), .uv_i(uv), .oc_i(oc), .op_i(op), .cmp_o(cmp));
    line_brownout_fault_sequencer #(.BLANK_CYC(BL), .WINDOW_CYC(BL)) line_brownout_fault_sequencer_i (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .undervoltage_compare_i(cmp.undervoltage),
        .overcurrent_i(cmp.overcurrent), .overpower_i(cmp.overpower), .pwm_i(pwm), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .line_fault_flag_o(flt), .gate_drive_o(gate), .ctrl_ground_o(gnd),
        .hold_clamp_o(clamp), .hysteresis_sink_o(sink), .sense_pulldown_o(pull), .irq_o(irq));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o;
        cyc <= 0; stb <= 0;
        if (k >= 20) test_done_fail();
    endtask
    task automatic test_done_fail();
        failures++;
        test_done();
    endtask
    // counts edges until the flag reaches v; running out of edges ends the run
    task automatic wait_flt(input logic v);
        n = 0;
        while (flt !== v && n < 200) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 200) test_done_fail();
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1;
        @(posedge ref_clk_i);
        `CHK("fault", 1'b1, flt)
        `CHK("pulldown", 1'b1, pull)
        bus(1, 8'h0C, 32'h1);
        bus(1, 8'h00, 32'h3);
        repeat (6) @(posedge ref_clk_i);
        `CHK("fault", 1'b0, flt)
        `CHK("pulldown", 1'b0, pull)
        bus(0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
        uv <= 1;
        repeat (10) @(posedge ref_clk_i);
        `CHK("clamp", 1'b1, clamp)
        uv <= 0;
        repeat (60) @(posedge ref_clk_i);
        `CHK("fault", 1'b0, flt)
        `CHK("clamp", 1'b0, clamp)
        uv <= 1;
        wait_flt(1);
        `CHK("delay", 1'b1, n >= BL && n <= BL + 8)
        `CHK("sink", 1'b1, sink)
        `CHK("ground", 1'b1, gnd)
        `CHK("irq", 1'b1, irq)
        bus(0, 8'h04, 32'h0);
        `CHK("status", 4'hF, q[3:0])
        bus(1, 8'h08, 32'hF);
        @(posedge ref_clk_i);
        `CHK("irq", 1'b0, irq)
        uv <= 0;
        wait_flt(0);
        repeat (40) begin
            seed = xs(seed);
            oc <= seed[0]; op <= seed[1]; pwm <= seed[2];
            repeat (5) @(posedge ref_clk_i);
            `CHK("gate", seed[2] & ~seed[0] & ~seed[1], gate)
        end
        test_done();
    end
endmodule
bind line_brownout_fault_sequencer line_fault_chk line_fault_chk_i (.ref_clk_i, .rstn_i, .overcurrent_i,
    .overpower_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .line_fault_flag_o, .gate_drive_o, .ctrl_ground_o,
    .hold_clamp_o, .sense_pulldown_o);
`default_nettype wire
